// [hw/twi_wait_ctrl.v]
`timescale 1ns/100ps
`include "twi_wait_regs.vh"
// Operation
// - Register accepts byte writes and single-bit writes through a bit mask.
// - Reset clears the register; bit 7 always reads zero.
// - Wait select 00 raises interrupt at 8th clock rise; clock stays released.
// - Wait select 10 interrupts at 8th rise, then holds clock low.
// - Wait select 11 interrupts at 9th rise, then holds clock low.
// - Writing wait release ends the wait, then the bit self-clears.
// - Clock level bit zero and idle drives the clock pin low, except in wait select 00.
// - Clock level bit one and idle releases the clock pin high.
// - Address mask select compares bits 0-7 or only bits 1-7.
// - Interrupt source select adds stop detection as an interrupt cause.
// - Clock pin level bit reports pin level, zero when disabled.
// - Start trigger drops data while clock high; start detection sets flag.
// - Stop trigger raises data while clock high; detection sets stop flag.
// - Receiver holds data low one clock as acknowledge; detection flags it.
// - Slave holds clock low as wait for 1x; no flag changes.
// - First byte after start carries 7-bit address; completion sets interrupt.
// - Direction bit follows the address.
// - Later bytes are 8-bit data; completion sets interrupt flag.
// - Transmit MSB first, next bit after each rising edge; sample on rising edges.
module twi_wait_ctrl #(
    parameter DATA_W = 8
) (
    input wire clk_in,
    input wire nrst_in,
    input wire [15:0] addr_in,
    input wire wr_in,
    input wire [7:0] wr_mask_in,
    input wire [7:0] wr_data_in,
    output reg [7:0] rd_data_out,
    input wire channel_enable_in,
    input wire wakeup_enable_in,
    input wire start_trigger_in,
    input wire stop_trigger_in,
    input wire ack_trigger_in,
    input wire ack_auto_enable_in,
    input wire tx_enable_in,
    input wire [DATA_W-1:0] slave_address_reg_in,
    input wire shift_load_in,
    input wire [DATA_W-1:0] shift_data_in,
    output reg [DATA_W-1:0] shift_reg_out,
    output reg channel_irq_out,
    output reg start_detected_out,
    output reg stop_detected_out,
    output reg ack_detected_out,
    output reg address_match_out,
    output reg busy_out,
    input wire scl_in,
    output reg scl_out,
    output reg scl_oe_out,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe_out
);
    // ****************************************************************
    // Control register.
    // ****************************************************************
    reg [1:0] wait_sel_reg;
    reg wait_release_reg;
    reg clock_level_release_reg;
    reg address_mask_select_reg;
    reg interrupt_source_select_reg;
    reg waiting_reg;
    reg [3:0] bit_cnt_reg;
    reg first_byte_reg;
    reg ack_phase_reg;
    reg pend_start_reg;
    reg pend_stop_reg;
    reg pend_ack_reg;
    reg sda_drive_low_reg;
    reg [7:0] view_comb;

    wire scl_lvl;
    wire scl_rise;
    wire scl_fall;
    wire sda_lvl;
    wire sda_rise;
    wire sda_fall;
    wire sel_hit;
    wire [7:0] merged;
    wire [3:0] irq_count;
    wire byte_end;
    wire start_cond;
    wire stop_cond;
    wire [DATA_W-1:0] cmp_mask;

    line_sync scl_sync (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .line_in(scl_in),
        .level_out(scl_lvl),
        .rise_out(scl_rise),
        .fall_out(scl_fall)
    );

    line_sync sda_sync (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .line_in(sda_in),
        .level_out(sda_lvl),
        .rise_out(sda_rise),
        .fall_out(sda_fall)
    );

    assign sel_hit = wr_in && (addr_in == `WCC_ADDR);
    // Bits outside the mask keep their value, giving single-bit writes.
    assign merged = (wr_data_in & wr_mask_in) | (view_comb & ~wr_mask_in);

    // Current register image with the pin level folded in.
    // A process rather than a function, so the write merge follows every field change.
    always @* begin
        view_comb = 8'h00;
        view_comb[`WCC_WAIT_SEL_HI:`WCC_WAIT_SEL_LO] = wait_sel_reg;
        view_comb[`WCC_WAIT_RELEASE] = wait_release_reg;
        view_comb[`WCC_CLOCK_LEVEL_RELEASE] = clock_level_release_reg;
        view_comb[`WCC_ADDRESS_MASK_SELECT] = address_mask_select_reg;
        view_comb[`WCC_INTERRUPT_SOURCE_SELECT] = interrupt_source_select_reg;
        view_comb[`WCC_CLOCK_PIN_LEVEL] = scl_lvl & channel_enable_in;
    end

    // Interrupt edge: 9th rise only in 9-clock wait mode, else 8th.
    assign irq_count = (wait_sel_reg == `WCC_WAIT_9) ? `WCC_BIT_COUNT_9 : `WCC_BIT_COUNT_8;
    assign byte_end = busy_out && scl_rise && ((bit_cnt_reg + 4'h1) == irq_count);
    // Conditions are data edges while the clock is high.
    assign start_cond = sda_fall && scl_lvl;
    assign stop_cond = sda_rise && scl_lvl;
    // Bit 0 drops out of the compare when the mask select is set.
    assign cmp_mask = {{(DATA_W-1){1'b1}}, ~address_mask_select_reg};

    // ****************************************************************
    // Register writes and read-back.
    // ****************************************************************
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            wait_sel_reg <= 2'h0;
            wait_release_reg <= 1'b0;
            clock_level_release_reg <= 1'b0;
            address_mask_select_reg <= 1'b0;
            interrupt_source_select_reg <= 1'b0;
            rd_data_out <= `WCC_RESET;
        end else begin
            if (sel_hit) begin
                wait_sel_reg <= merged[`WCC_WAIT_SEL_HI:`WCC_WAIT_SEL_LO];
                clock_level_release_reg <= merged[`WCC_CLOCK_LEVEL_RELEASE];
                address_mask_select_reg <= merged[`WCC_ADDRESS_MASK_SELECT];
                interrupt_source_select_reg <= merged[`WCC_INTERRUPT_SOURCE_SELECT];
            end
            // Release is acted on in the next cycle, then reads zero.
            if (sel_hit && merged[`WCC_WAIT_RELEASE]) begin
                wait_release_reg <= 1'b1;
            end else if (wait_release_reg) begin
                wait_release_reg <= 1'b0;
            end
            rd_data_out <= view_comb;
        end
    end

    // ****************************************************************
    // Transfer engine: bit counting, shifting, flags and waits.
    // ****************************************************************
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            busy_out <= 1'b0;
            waiting_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            first_byte_reg <= 1'b0;
            ack_phase_reg <= 1'b0;
            shift_reg_out <= {DATA_W{1'b0}};
            channel_irq_out <= 1'b0;
            start_detected_out <= 1'b0;
            stop_detected_out <= 1'b0;
            ack_detected_out <= 1'b0;
            address_match_out <= 1'b0;
            pend_start_reg <= 1'b0;
            pend_stop_reg <= 1'b0;
            pend_ack_reg <= 1'b0;
            sda_drive_low_reg <= 1'b0;
        end else if (!channel_enable_in) begin
            busy_out <= 1'b0;
            ack_phase_reg <= 1'b0;
            waiting_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            channel_irq_out <= 1'b0;
            start_detected_out <= 1'b0;
            stop_detected_out <= 1'b0;
            ack_detected_out <= 1'b0;
            pend_start_reg <= 1'b0;
            pend_stop_reg <= 1'b0;
            pend_ack_reg <= 1'b0;
            sda_drive_low_reg <= 1'b0;
        end else begin
            channel_irq_out <= 1'b0;
            // Triggers drive the data latch; the master frames them with the clock.
            if (start_trigger_in) begin
                sda_drive_low_reg <= 1'b1;
            end else if (stop_trigger_in) begin
                sda_drive_low_reg <= 1'b0;
            end
            if (ack_trigger_in) begin
                pend_ack_reg <= 1'b1;
            end
            if (start_cond) begin
                start_detected_out <= 1'b1;
                first_byte_reg <= 1'b1;
                stop_detected_out <= 1'b0;
            end
            if (stop_cond) begin
                stop_detected_out <= 1'b1;
                start_detected_out <= 1'b0;
                busy_out <= 1'b0;
                waiting_reg <= 1'b0;
                // A stale acknowledge slot would pull data low at the next start.
                ack_phase_reg <= 1'b0;
                channel_irq_out <= interrupt_source_select_reg;
            end
            // A write to the shift register starts a transfer and clears the flags.
            if (shift_load_in) begin
                shift_reg_out <= shift_data_in;
                busy_out <= 1'b1;
                bit_cnt_reg <= 4'h0;
                start_detected_out <= 1'b0;
                stop_detected_out <= 1'b0;
                ack_detected_out <= 1'b0;
                waiting_reg <= 1'b0;
                ack_phase_reg <= 1'b0;
            end else if (busy_out && scl_rise && !stop_cond) begin
                // Sample on the rising edge, MSB arrives first.
                if (bit_cnt_reg < `WCC_BIT_COUNT_8) begin
                    shift_reg_out <= {shift_reg_out[DATA_W-2:0], sda_lvl};
                end else if (!sda_lvl) begin
                    ack_detected_out <= 1'b1;
                end
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                if (byte_end) begin
                    // End of address byte (7 bits + direction) or of a data byte.
                    channel_irq_out <= !wakeup_enable_in || !first_byte_reg ||
                        (((shift_reg_out[DATA_W-2:0] ^ slave_address_reg_in[DATA_W-1:1]) & cmp_mask[DATA_W-1:1])
                         == {(DATA_W-1){1'b0}});
                    if (wait_sel_reg[1]) begin
                        waiting_reg <= 1'b1;
                    end
                end
                if (bit_cnt_reg == `WCC_BIT_COUNT_8 - 4'h1) begin
                    address_match_out <= (((({shift_reg_out[DATA_W-2:0], sda_lvl}) ^ slave_address_reg_in)
                        & cmp_mask) == {DATA_W{1'b0}});
                    first_byte_reg <= 1'b0;
                    ack_phase_reg <= 1'b1;
                end
                if (bit_cnt_reg == `WCC_BIT_COUNT_9 - 4'h1) begin
                    busy_out <= 1'b0;
                    ack_phase_reg <= 1'b0;
                end
            end
            if (wait_release_reg) begin
                waiting_reg <= 1'b0;
            end
            if (busy_out && scl_fall) begin
                pend_ack_reg <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Pin drivers: open drain, so only a low is ever driven.
    // ****************************************************************
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            scl_out <= 1'b0;
            scl_oe_out <= 1'b0;
            sda_out <= 1'b0;
            sda_oe_out <= 1'b0;
        end else begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            if (!channel_enable_in || wait_sel_reg == 2'h0) begin
                scl_oe_out <= 1'b0;
            end else if (waiting_reg) begin
                scl_oe_out <= 1'b1;
            end else if (!busy_out) begin
                scl_oe_out <= !clock_level_release_reg;
            end else begin
                scl_oe_out <= 1'b0;
            end
            // During a byte the MSB-first data bit drives low on zero, after the rising edge that shifts it up.
            if (!channel_enable_in) begin
                sda_oe_out <= 1'b0;
            end else if (busy_out && !ack_phase_reg) begin
                sda_oe_out <= tx_enable_in & ~shift_reg_out[DATA_W-1];
            end else if (ack_phase_reg) begin
                // The acknowledge starts only while the clock is low, so it never looks like a start.
                sda_oe_out <= (pend_ack_reg | ack_auto_enable_in) & (sda_oe_out | ~scl_lvl);
            end else begin
                sda_oe_out <= sda_drive_low_reg;
            end
        end
    end
endmodule

// [hw/twi_wait_regs.vh]
`ifndef TWI_WAIT_REGS_VH
`define TWI_WAIT_REGS_VH
// ****************************************************************
// Register map and field layout of the wait and clock control register.
// ****************************************************************
`define WCC_ADDR 16'hff63
`define WCC_RESET 8'h00
`define WCC_WAIT_SEL_LO 0
`define WCC_WAIT_SEL_HI 1
`define WCC_WAIT_RELEASE 2
`define WCC_CLOCK_LEVEL_RELEASE 3
`define WCC_ADDRESS_MASK_SELECT 4
`define WCC_INTERRUPT_SOURCE_SELECT 5
`define WCC_CLOCK_PIN_LEVEL 6
`define WCC_WAIT_8 2'h2
`define WCC_WAIT_9 2'h3
`define WCC_BIT_COUNT_8 4'h8
`define WCC_BIT_COUNT_9 4'h9
`endif

// [hw/line_sync.v]
`timescale 1ns/100ps
// ****************************************************************
// Two-stage synchroniser with edge detection on the settled stage.
// ****************************************************************
module line_sync (
    input wire clk_in,
    input wire nrst_in,
    input wire line_in,
    output reg level_out,
    output wire rise_out,
    output wire fall_out
);
    reg meta_reg;
    reg prev_reg;

    // Lines idle high on an open-drain bus, so reset to one.
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta_reg <= 1'b1;
            level_out <= 1'b1;
            prev_reg <= 1'b1;
        end else begin
            meta_reg <= line_in;
            level_out <= meta_reg;
            prev_reg <= level_out;
        end
    end

    // Edges are taken only from the second stage.
    assign rise_out = level_out & ~prev_reg;
    assign fall_out = ~level_out & prev_reg;
endmodule

// [dv/twi_bus_partner.sv]
`timescale 1ns/100ps
// ********
// Bus master model: open-drain clock and data, 160 ns bit period.
// ********
module twi_bus_partner (
    input wire scl_in,
    output reg scl_low_out,
    output reg sda_low_out,
    output reg hang_out
);
    integer k;
    initial begin
        scl_low_out = 1'b0;
        sda_low_out = 1'b0;
        hang_out = 1'b0;
    end
    // Let the clock go and honour a stretching slave, but never wait forever.
    task free_scl;
        begin
            scl_low_out = 1'b0;
            for (k = 0; k < 400 && scl_in !== 1'b1; k = k + 1) #20;
            if (k == 400) hang_out = 1'b1;
        end
    endtask
    // Data falls while the clock is high.
    task start_cond;
        begin
            free_scl;
            #80 sda_low_out = 1'b1;
            #80 scl_low_out = 1'b1;
        end
    endtask
    // Data rises while the clock is high; the clock then stands still.
    task stop_cond;
        begin
            sda_low_out = 1'b1;
            #80 free_scl;
            #80 sda_low_out = 1'b0;
            #80;
        end
    endtask
    // Data changes only while the clock is low, so the receiver samples it on the rise.
    task send_bit(input v);
        begin
            sda_low_out = ~v;
            #80 free_scl;
            #80 scl_low_out = 1'b1;
        end
    endtask
    task send_byte(input [7:0] v);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) send_bit(v[i]);
        end
    endtask
endmodule

// [dv/twi_wait_ctrl_checker.sv]
`timescale 1ns/100ps
// ********
// Port properties of the wait and clock control block.
// ********
module twi_wait_ctrl_checker (
    input wire clk_in,
    input wire nrst_in,
    input wire [15:0] addr_in,
    input wire wr_in,
    input wire [7:0] wr_mask_in,
    input wire [7:0] wr_data_in,
    input wire [7:0] rd_data_out,
    input wire channel_enable_in,
    input wire channel_irq_out,
    input wire start_detected_out,
    input wire stop_detected_out,
    input wire busy_out,
    input wire scl_oe_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);
    // A release write, and a byte finished in wait select 10, the one wait mode still busy at its interrupt.
    sequence s_rel;
        wr_in && addr_in == 16'hff63 && wr_mask_in[2] && wr_data_in[2];
    endsequence
    sequence s_bwait;
        channel_irq_out && busy_out && rd_data_out[1] && !wr_in;
    endsequence
    // A wait after a finished byte belongs to the transfer until release, stop or disable.
    reg held_reg;
    always @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            held_reg <= 1'b0;
        end else if (!channel_enable_in || stop_detected_out || (wr_in && addr_in == 16'hff63 && wr_mask_in[2]
                && wr_data_in[2])) begin
            held_reg <= 1'b0;
        end else if (channel_irq_out && rd_data_out[1]) begin
            held_reg <= 1'b1;
        end
    end
    // Idle levels get three cycles to settle after the level bit changes.
    property p_top; rd_data_out[7] == 1'b0; endproperty
    property p_off; !channel_enable_in [*2] |-> !rd_data_out[6]; endproperty
    property p_rel; s_rel |-> ##3 !rd_data_out[2]; endproperty
    property p_low; (channel_enable_in && !busy_out && !rd_data_out[3]) [*3] |-> scl_oe_out; endproperty
    property p_high; (channel_enable_in && !busy_out && !held_reg && rd_data_out[3]) [*3] |-> !scl_oe_out; endproperty
    property p_hold; s_bwait |-> ##[1:8] scl_oe_out; endproperty
    property p_nohold; (rd_data_out[3] && rd_data_out[1:0] == 2'b00) [*2] |-> !scl_oe_out; endproperty
    property p_stop; $rose(stop_detected_out) |-> !start_detected_out; endproperty
    property p_pulse; channel_irq_out |=> !channel_irq_out; endproperty
    a_top: assert property (p_top) else $error("bit 7 read as one");
    a_off: assert property (p_off) else $error("level seen while off");
    a_rel: assert property (p_rel) else $error("release bit stuck");
    a_low: assert property (p_low) else $error("idle clock not low");
    a_high: assert property (p_high) else $error("idle clock not freed");
    a_hold: assert property (p_hold) else $error("no clock hold");
    a_nohold: assert property (p_nohold) else $error("clock held in mode 0");
    a_stop: assert property (p_stop) else $error("start flag kept");
    a_pulse: assert property (p_pulse) else $error("irq too long");
endmodule
bind twi_wait_ctrl twi_wait_ctrl_checker chk (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
    .wr_in(wr_in), .wr_mask_in(wr_mask_in), .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
    .channel_enable_in(channel_enable_in), .channel_irq_out(channel_irq_out), .busy_out(busy_out),
    .start_detected_out(start_detected_out), .stop_detected_out(stop_detected_out), .scl_oe_out(scl_oe_out));

// [dv/testbench.sv]
`timescale 1ns/100ps
// ********
// Bench: register image, clock level, byte waits and bus conditions.
// ********
module testbench;
    reg clk_in = 1'b0, nrst = 1'b0, wr = 1'b0, en = 1'b0, st = 1'b0, sp = 1'b0, ld = 1'b0, ae = 1'b0;
    reg [15:0] a = 16'hff63, r = 16'h577f;
    reg [7:0] m = 8'h00, d = 8'h00, sa = 8'h00, b, sh = 8'h00;
    reg [1:0] md;
    wire [7:0] rd, sr;
    wire irq, sdet, pdet, adet, amat, busy, so, soe, dout, doe, pcl, pda, hang;
    // Open-drain lines with pull-ups: high unless a party pulls low.
    wire scl = ~((soe & ~so) | pcl);
    wire sda = ~((doe & ~dout) | pda);
    integer err_count = 0, tests_run = 0, irqs = 0, i;
    twi_wait_ctrl dut (.clk_in(clk_in), .nrst_in(nrst), .addr_in(a), .wr_in(wr), .wr_mask_in(m), .wr_data_in(d),
        .rd_data_out(rd), .channel_enable_in(en), .wakeup_enable_in(1'b0), .start_trigger_in(st),
        .stop_trigger_in(sp), .ack_trigger_in(1'b0), .ack_auto_enable_in(ae), .tx_enable_in(1'b0),
        .slave_address_reg_in(sa), .shift_load_in(ld), .shift_data_in(8'hff), .shift_reg_out(sr),
        .channel_irq_out(irq), .start_detected_out(sdet), .stop_detected_out(pdet), .ack_detected_out(adet),
        .address_match_out(amat), .busy_out(busy), .scl_in(scl), .scl_out(so), .scl_oe_out(soe), .sda_in(sda),
        .sda_out(dout), .sda_oe_out(doe));
    twi_bus_partner p (.scl_in(scl), .scl_low_out(pcl), .sda_low_out(pda), .hang_out(hang));
    always #10 clk_in = ~clk_in;
    always @(posedge clk_in) if (irq === 1'b1) irqs <= irqs + 1;
    function [15:0] lfsr(input [15:0] x);
        lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // Bits 7 and 2 read zero; bit 6 is the idle clock level, seen only when enabled.
    function [7:0] img(input [7:0] s);
        img = {1'b0, en & s[3], s[5:3], 1'b0, s[1:0]};
    endfunction
    task cmp(input [63:0] what, input [7:0] e, input [7:0] g);
        begin
            tests_run = tests_run + 1;
            if (g !== e) begin
                err_count = err_count + 1;
                $display("CHECK FAILED %0s expected %h seen %h", what, e, g);
            end
        end
    endtask
    task cyc(input integer n);
        begin
            repeat (n) @(posedge clk_in);
            #1;
        end
    endtask
    // One write; the shadow keeps only bits that hold a value, so callers let an edge pass after it.
    task wrr(input [15:0] ad, input [7:0] mk, input [7:0] dt);
        begin
            a = ad;
            m = mk;
            d = dt;
            wr = 1'b1;
            if (ad == 16'hff63) sh = (sh & ~mk | dt & mk) & 8'h3b;
            cyc(1);
            wr = 1'b0;
        end
    endtask
    task end_sim;
        begin
            $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
            if (err_count == 0 && tests_run > 0) begin
                $display("Finished cleanly");
            end else begin
                $display("Finished with errors");
            end
            $finish;
        end
    endtask
    initial begin
        cyc(10);
        nrst = 1'b1;
        cmp("reset", 8'h00, rd);
        wrr(16'hff63, 8'hff, 8'h0a);
        cyc(5);
        cmp("off", img(sh), rd);
        en = 1'b1;
        // Random byte and bit writes, some aimed at the unused neighbour address.
        for (i = 0; i < 16; i = i + 1) begin
            r = lfsr(r);
            wrr({15'h7fb1, ~r[11]}, r[8] ? 8'hff : 8'h08 << r[10:9], r[7:0] | 8'h02);
            cyc(5);
            cmp("image", img(sh), rd);
            cmp("level", {7'h00, ~sh[3]}, {7'h00, soe});
        end
        $display("register tests done");
        wrr(16'hff63, 8'hff, 8'h0b);
        cyc(5);
        st = 1'b1;
        cyc(1);
        st = 1'b0;
        cyc(4);
        cmp("mstart", 8'h03, {6'h00, doe, sdet});
        sp = 1'b1;
        cyc(1);
        sp = 1'b0;
        cyc(4);
        cmp("mstop", 8'h04, {5'h00, pdet, doe, sdet});
        $display("master conditions done");
        // The partner addresses the block in wait modes 00, 10 and 11; the stop waits for the clock to be freed.
        for (i = 0; i < 6; i = i + 1) begin
            r = lfsr(r);
            md = i % 3 == 0 ? 2'b00 : {1'b1, i % 3 == 2};
            sa = r[7:0];
            b = r[7:0] ^ {r[10] & r[11], 6'h00, r[9]};
            wrr(16'hff63, 8'hff, {2'h0, i[0], r[8], 2'h2, md});
            ae = md[0];
            p.start_cond;
            cyc(4);
            cmp("start", 8'h01, {7'h00, sdet});
            ld = 1'b1;
            cyc(1);
            ld = 1'b0;
            irqs = 0;
            p.send_byte(b);
            cyc(4);
            cmp("irq8", {7'h00, md != 2'b11}, irqs[7:0]);
            cmp("ackout", {7'h00, md[0]}, {7'h00, doe});
            if (md == 2'b11) p.send_bit(1'b0);
            cyc(10);
            cmp("irq", 8'h01, irqs[7:0]);
            if (md != 2'b11) cmp("shift", b, sr);
            if (md == 2'b11) cmp("ack", 8'h01, {7'h00, adet});
            cmp("match", {7'h00, b[7:1] == sa[7:1] && (r[8] || b[0] == sa[0])}, {7'h00, amat});
            cmp("wait", {5'h00, md[1], 2'b00}, {5'h00, soe, pdet, sdet});
            wrr(16'hff63, 8'h04, 8'h04);
            cyc(2);
            cmp("freed", 8'h00, {6'h00, rd[2], soe});
            p.stop_cond;
            cyc(4);
            cmp("stop", 8'h02, {6'h00, pdet, sdet});
            cmp("irqstop", 8'h01 + i[0], irqs[7:0]);
            $display("transfer %0d in wait mode %b done", i, md);
        end
        cmp("hang", 8'h00, {7'h00, hang});
        end_sim;
    end
    initial begin
        #1500000;
        err_count = err_count + 1;
        end_sim;
    end
endmodule
